// ==== hw/rmx_decode.sv ====
// decoding of a 4-bit line input level field
`timescale 1ns/100ps
`default_nettype none
module rmx_decode (
    // level field
    input wire logic [3:0] level,
    input wire logic diff,
    // decoded settings
    output rmx_pkg::rmx_input_s dec
);
    logic connected;
    logic [3:0] atten;

    // any code other than the off code connects the input
    assign connected = (level != rmx_pkg::LEVEL_OFF);
    // each code step is 1.5 dB; kept as the code for the analog trim
    assign atten = connected ? level : rmx_pkg::LEVEL_12DB;
    assign dec = '{diff: diff, connected: connected, atten_half_db: atten};
endmodule
`default_nettype wire

// ==== hw/rmx_reg8.sv ====
// one 8-bit control register with write mask and reset value
`timescale 1ns/100ps
`default_nettype none
module rmx_reg8 #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WMASK = 8'hFF
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write port
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // stored value
    output logic [7:0] q
);
    logic [7:0] next_q;

    // read-only bits keep their reset value whatever is written
    assign next_q = wr_en ? ((wr_data & WMASK) | (RESET_VAL & ~WMASK)) : q;

    // storage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= RESET_VAL;
        end else begin
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// ==== hw/rmx_top.sv ====
// register bank steering the right adc input mix
`timescale 1ns/100ps
`default_nettype none

// How it works
// - bit 7 of the first register selects single-ended (0) or differential (1) for line one.
// - bits 6..3 of the first register set attenuation from 0 dB down 1.5 dB a step to -12 dB.
// - any gain code connects line one to the mix and code 1111, the reset value, disconnects.
// - bit 2 of the first register powers the right adc up when set, reset leaves it down.
// - bits 1..0 pick soft-stepping each sample, each two samples, or none for 10 and 11.
// - bit 7 of the second register selects single-ended or differential for line two.
// - line two level gives 0, -6 or -12 dB for 0000, 0100, 1000 and 1111 disconnects.
// - bit 2 of the second register weakly biases unselected inputs to common mode.
// - bits 1..0 of the second register are read-only zero and software writes zeros.
module rmx_top (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register access port of the control bus
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // settings to the analog mixer and adc
    output rmx_pkg::rmx_ctrl_s ctrl
);

    // ************************************************************
    // address decode
    // ************************************************************
    logic [7:0] line_one_q;
    logic [7:0] line_two_q;
    logic sel_one;
    logic sel_two;
    logic [7:0] next_rdata;

    // decode shared by read and write paths
    assign sel_one = (reg_addr == rmx_pkg::ADDR_LINE_ONE);
    assign sel_two = (reg_addr == rmx_pkg::ADDR_LINE_TWO);
    assign reg_hit = sel_one | sel_two;

    // ************************************************************
    // registers
    // ************************************************************
    rmx_reg8 #(
        .RESET_VAL(rmx_pkg::RST_LINE_ONE),
        .WMASK(rmx_pkg::WMASK_LINE_ONE)
    ) u_line_one (
        .clk(clk),
        .nrst(nrst),
        .wr_en(reg_wr & sel_one),
        .wr_data(reg_wdata),
        .q(line_one_q)
    );

    // low two bits masked so they stay zero
    rmx_reg8 #(
        .RESET_VAL(rmx_pkg::RST_LINE_TWO),
        .WMASK(rmx_pkg::WMASK_LINE_TWO)
    ) u_line_two (
        .clk(clk),
        .nrst(nrst),
        .wr_en(reg_wr & sel_two),
        .wr_data(reg_wdata),
        .q(line_two_q)
    );

    // unmapped addresses read as zero
    assign next_rdata = sel_one ? line_one_q : (sel_two ? line_two_q : 8'h00);

    // registered read data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ************************************************************
    // field decode
    // ************************************************************
    rmx_pkg::rmx_input_s dec_one;
    rmx_pkg::rmx_input_s dec_two;
    rmx_pkg::rmx_step_e step;
    logic [1:0] step_code;

    rmx_decode u_dec_one (
        .level(line_one_q[rmx_pkg::LEVEL_HI:rmx_pkg::LEVEL_LO]),
        .diff(line_one_q[rmx_pkg::DIFF_BIT]),
        .dec(dec_one)
    );

    rmx_decode u_dec_two (
        .level(line_two_q[rmx_pkg::LEVEL_HI:rmx_pkg::LEVEL_LO]),
        .diff(line_two_q[rmx_pkg::DIFF_BIT]),
        .dec(dec_two)
    );

    // codes 10 and 11 both fold into off
    assign step_code = line_one_q[rmx_pkg::STEP_HI:rmx_pkg::STEP_LO];
    assign step = (step_code == rmx_pkg::STEP_PER_FS) ? rmx_pkg::RMX_STEP_ONE :
        (step_code == rmx_pkg::STEP_PER_TWO_FS) ? rmx_pkg::RMX_STEP_TWO :
        rmx_pkg::RMX_STEP_OFF;

    // ************************************************************
    // control outputs, registered
    // ************************************************************
    rmx_pkg::rmx_ctrl_s next_ctrl;

    assign next_ctrl = '{
        line_one: dec_one,
        line_two: dec_two,
        adc_power: line_one_q[rmx_pkg::PWR_BIT],
        weak_bias: line_two_q[rmx_pkg::BIAS_BIT],
        step: step
    };

    // one cycle behind the register, keeps analog controls glitch free
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl <= '{
                line_one: '{diff: 1'b0, connected: 1'b0, atten_half_db: rmx_pkg::LEVEL_12DB},
                line_two: '{diff: 1'b0, connected: 1'b0, atten_half_db: rmx_pkg::LEVEL_12DB},
                adc_power: 1'b0,
                weak_bias: 1'b0,
                step: rmx_pkg::RMX_STEP_ONE
            };
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // the ctrl stage has its own reset, so a check that looks one edge back
    // skips the first edge after reset, when the past bytes are stale

    // level field of a stored register byte
    function automatic logic [3:0] level_of(input logic [7:0] r);
        return r[rmx_pkg::LEVEL_HI:rmx_pkg::LEVEL_LO];
    endfunction

    // soft-stepping field of the first register byte
    function automatic logic [1:0] step_of(input logic [7:0] r);
        return r[rmx_pkg::STEP_HI:rmx_pkg::STEP_LO];
    endfunction

    // the one level code that cuts an input off the mix
    function automatic logic is_cut(input logic [3:0] lvl);
        return lvl == rmx_pkg::LEVEL_OFF;
    endfunction

    // ************************************************************
    // reset values
    // ************************************************************
    // line one comes out of reset cut off, single-ended and powered down
    a_reset_one: assert property (@(posedge clk) disable iff (!nrst)
        !$past(nrst)
        |-> line_one_q == rmx_pkg::RST_LINE_ONE)
        else $error("line one register not at its reset value");

    // line two comes out of reset cut off with no weak bias
    a_reset_two: assert property (@(posedge clk) disable iff (!nrst)
        !$past(nrst)
        |-> line_two_q == rmx_pkg::RST_LINE_TWO)
        else $error("line two register not at its reset value");

    // the analog side sees nothing connected and the adc down after reset
    a_reset_ctrl: assert property (@(posedge clk) disable iff (!nrst)
        !$past(nrst)
        |-> !ctrl.adc_power && !ctrl.weak_bias && !ctrl.line_one.connected
            && !ctrl.line_two.connected)
        else $error("ctrl not at its reset value");

    // ************************************************************
    // register writes
    // ************************************************************
    // a write to line one lands whole at its own edge
    a_write_one: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && sel_one
        |=> line_one_q == $past(reg_wdata))
        else $error("line one write did not land");

    // a write to line two lands except for its read-only low bits
    a_write_two: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && sel_two
        |=> line_two_q == ($past(reg_wdata) & rmx_pkg::WMASK_LINE_TWO))
        else $error("line two write did not land");

    // without a write that hits, both bytes keep their settings
    a_hold_idle: assert property (@(posedge clk) disable iff (!nrst)
        !(reg_wr && reg_hit)
        |=> $stable(line_one_q) && $stable(line_two_q))
        else $error("register changed without a write");

    // the low bits of line two stay zero even when ones are written
    a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && sel_two
        |=> line_two_q[rmx_pkg::STEP_HI:rmx_pkg::STEP_LO] == 2'b00)
        else $error("reserved bits not zero");

    // and they never leave zero between writes either
    a_reserved_held: assert property (@(posedge clk) disable iff (!nrst)
        1'b1
        |-> line_two_q[rmx_pkg::STEP_HI:rmx_pkg::STEP_LO] == 2'b00)
        else $error("reserved bits left zero");

    // ************************************************************
    // read path
    // ************************************************************
    // the byte at line one's address shows up one edge after the address
    a_read_one: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && $past(sel_one)
        |-> reg_rdata == $past(line_one_q))
        else $error("line one read data wrong");

    // same for line two
    a_read_two: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && $past(sel_two)
        |-> reg_rdata == $past(line_two_q))
        else $error("line two read data wrong");

    // software always reads the reserved bits of line two as zero
    a_read_reserved: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && $past(sel_two)
        |-> reg_rdata[rmx_pkg::STEP_HI:rmx_pkg::STEP_LO] == 2'b00)
        else $error("reserved bits read back nonzero");

    // ************************************************************
    // line one and adc power
    // ************************************************************
    // wiring mode of line one follows its top bit one edge late
    a_diff_one: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst)
        |-> ctrl.line_one.diff == $past(line_one_q[rmx_pkg::DIFF_BIT]))
        else $error("line one wiring mode wrong");

    // every code but the cut-off code connects line one to the mix
    a_connect_one: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst)
        |-> ctrl.line_one.connected == !is_cut(level_of($past(line_one_q))))
        else $error("line one connection wrong");

    // a legal gain code goes to the analog trim unchanged, in 1.5 db steps
    a_atten_one: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && level_of($past(line_one_q)) <= rmx_pkg::LEVEL_12DB
        |-> ctrl.line_one.atten_half_db == level_of($past(line_one_q)))
        else $error("line one attenuation wrong");

    // a cut-off input parks its trim at the deepest legal step
    a_cut_one: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && is_cut(level_of($past(line_one_q)))
        |-> ctrl.line_one.atten_half_db == rmx_pkg::LEVEL_12DB)
        else $error("line one trim not parked when cut off");

    // adc power follows a write two edges later, register then ctrl stage
    a_power_follows: assert property (@(posedge clk) disable iff (!nrst)
        reg_wr && sel_one
        |-> ##2 ctrl.adc_power == $past(reg_wdata[rmx_pkg::PWR_BIT], 2))
        else $error("adc power does not follow write");

    // and it keeps matching the stored bit between writes
    a_power_level: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst)
        |-> ctrl.adc_power == $past(line_one_q[rmx_pkg::PWR_BIT]))
        else $error("adc power does not match register");

    // ************************************************************
    // soft-stepping
    // ************************************************************
    // code 00 steps the gain once per sample period
    a_step_each: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && step_of($past(line_one_q)) == rmx_pkg::STEP_PER_FS
        |-> ctrl.step == rmx_pkg::RMX_STEP_ONE)
        else $error("stepping not once per sample");

    // code 01 steps once every two sample periods
    a_step_pair: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && step_of($past(line_one_q)) == rmx_pkg::STEP_PER_TWO_FS
        |-> ctrl.step == rmx_pkg::RMX_STEP_TWO)
        else $error("stepping not once per two samples");

    // codes 10 and 11 both turn stepping off
    a_step_off: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && $past(line_one_q[rmx_pkg::STEP_HI])
        |-> ctrl.step == rmx_pkg::RMX_STEP_OFF)
        else $error("stepping not disabled");

    // ************************************************************
    // line two and weak bias
    // ************************************************************
    // wiring mode of line two follows its top bit one edge late
    a_diff_two: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst)
        |-> ctrl.line_two.diff == $past(line_two_q[rmx_pkg::DIFF_BIT]))
        else $error("line two wiring mode wrong");

    // only the cut-off code leaves line two off the mix
    a_connect_two: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst)
        |-> ctrl.line_two.connected == !is_cut(level_of($past(line_two_q))))
        else $error("line two connection wrong");

    // the legal codes for 0, -6 and -12 db reach the trim as stored
    a_atten_two: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && !is_cut(level_of($past(line_two_q)))
        |-> ctrl.line_two.atten_half_db == level_of($past(line_two_q)))
        else $error("line two attenuation wrong");

    // a cut-off line two parks its trim at the deepest legal step
    a_cut_two: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) && is_cut(level_of($past(line_two_q)))
        |-> ctrl.line_two.atten_half_db == rmx_pkg::LEVEL_12DB)
        else $error("line two trim not parked when cut off");

    // weak common-mode bias follows its stored bit one edge late
    a_bias_follows: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst)
        |-> ctrl.weak_bias == $past(line_two_q[rmx_pkg::BIAS_BIT]))
        else $error("weak bias wrong");
endmodule
`default_nettype wire

// ==== shared/rmx_pkg.sv ====
// package for the right adc input mix control register bank
package rmx_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_LINE_ONE = 8'h16;
    localparam logic [7:0] ADDR_LINE_TWO = 8'h17;
    localparam logic [7:0] RST_LINE_ONE = 8'h78;
    localparam logic [7:0] RST_LINE_TWO = 8'h78;
    localparam logic [7:0] WMASK_LINE_ONE = 8'hFF;
    localparam logic [7:0] WMASK_LINE_TWO = 8'hFC;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int DIFF_BIT = 7;
    localparam int LEVEL_HI = 6;
    localparam int LEVEL_LO = 3;
    localparam int PWR_BIT = 2;
    localparam int BIAS_BIT = 2;
    localparam int STEP_HI = 1;
    localparam int STEP_LO = 0;

    // ************************************************************
    // level and stepping codes
    // ************************************************************
    localparam logic [3:0] LEVEL_0DB = 4'h0;
    localparam logic [3:0] LEVEL_6DB = 4'h4;
    localparam logic [3:0] LEVEL_12DB = 4'h8;
    localparam logic [3:0] LEVEL_OFF = 4'hF;
    localparam logic [1:0] STEP_PER_FS = 2'h0;
    localparam logic [1:0] STEP_PER_TWO_FS = 2'h1;

    typedef enum logic [1:0] {
        RMX_STEP_ONE = 2'b00,
        RMX_STEP_TWO = 2'b01,
        RMX_STEP_OFF = 2'b10
    } rmx_step_e;

    // decoded settings of one line input
    typedef struct packed {
        logic diff;
        logic connected;
        logic [3:0] atten_half_db;
    } rmx_input_s;

    // decoded channel settings for the analog side
    typedef struct packed {
        rmx_input_s line_one;
        rmx_input_s line_two;
        logic adc_power;
        logic weak_bias;
        rmx_step_e step;
    } rmx_ctrl_s;

endpackage

// ==== verification/test_rmx_top.sv ====
// self-checking testbench for the right adc input mix register bank
`timescale 1ns/100ps
`default_nettype none
module test_rmx_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_hit;
    rmx_pkg::rmx_ctrl_s ctrl;
    logic [7:0] r1, r2;
    logic [3:0] lvl;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    rmx_top uut (
        .clk(clk),
        .nrst(nrst),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_hit(reg_hit),
        .ctrl(ctrl)
    );

    // 10 mhz clock
    always #50 clk = ~clk;

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic wrap_up;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard, the whole run needs well under this
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors = errors + 1;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // leaves the strobe high so writes can run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
    endtask

    // read data is registered: one edge after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_wr = 1'b0;
        reg_addr = a;
        @(posedge clk);
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    // our own decode of the two registers, forced atten 8 when cut off
    function automatic rmx_pkg::rmx_ctrl_s exp_ctrl(input logic [7:0] a, input logic [7:0] b);
        rmx_pkg::rmx_ctrl_s e;
        e.line_one.diff = a[7];
        e.line_one.connected = (a[6:3] != 4'hF);
        e.line_one.atten_half_db = (a[6:3] == 4'hF) ? 4'h8 : a[6:3];
        e.line_two.diff = b[7];
        e.line_two.connected = (b[6:3] != 4'hF);
        e.line_two.atten_half_db = (b[6:3] == 4'hF) ? 4'h8 : b[6:3];
        e.adc_power = a[2];
        e.weak_bias = b[2];
        e.step = (a[1:0] == 2'h0) ? rmx_pkg::RMX_STEP_ONE :
                 (a[1:0] == 2'h1) ? rmx_pkg::RMX_STEP_TWO : rmx_pkg::RMX_STEP_OFF;
        return e;
    endfunction

    // read both back, then give the ctrl stage time to land
    task automatic check_all;
        rd(8'h16, r1);
        rd(8'h17, r2);
        @(posedge clk);
        #1;
        chk(ctrl, exp_ctrl(r1, r2));
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge clk);
        #1;
        nrst = 1'b1;
        r1 = 8'h78;
        r2 = 8'h78;
        check_all();
        chk(ctrl, 16'h2080);
        // line one: every legal level plus cut-off, all step codes
        for (int i = 0; i < 10; i++) begin
            lvl = (i < 9) ? 4'(i) : 4'hF;
            r1 = {i[0], lvl, i[1], i[1:0]};
            wr(8'h16, r1);
            check_all();
        end
        // line two: legal levels, low bits written as ones stay zero
        for (int i = 0; i < 4; i++) begin
            lvl = (i < 3) ? 4'(i * 4) : 4'hF;
            wr(8'h17, {i[0], lvl, i[1], 2'h3});
            r2 = {i[0], lvl, i[1], 2'h0};
            check_all();
        end
        // back to back writes to both registers
        r1 = 8'h87;
        r2 = 8'hC4;
        wr(8'h16, r1);
        wr(8'h17, r2);
        check_all();
        // unmapped address is ignored and reads zero
        wr(8'h18, 8'hFF);
        chk({15'h0000, reg_hit}, 16'h0000);
        rd(8'h18, 8'h00);
        rd(8'h17, r2);
        chk({15'h0000, reg_hit}, 16'h0001);
        check_all();
        // reset in mid-run restores both registers
        nrst = 1'b0;
        @(posedge clk);
        #1;
        nrst = 1'b1;
        r1 = 8'h78;
        r2 = 8'h78;
        check_all();
        wrap_up();
    end
endmodule
`default_nettype wire
